/* src/spm_pin_mux.v */
// Pin mux and general-purpose I/O for ports A and B, with an APB register slave.
// Assumes pads are resolved outside from out/oe_n; peripherals sit on pclk.
`timescale 1ns/1ns
`default_nettype none
`include "spm_consts.vh"
module spm_pin_mux (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire [7:0] port_a_pad_in,
  output reg [7:0] port_a_pad_out,
  output reg [7:0] port_a_pad_oe_n,
  input wire [7:0] port_b_pad_in,
  output reg [7:0] port_b_pad_out,
  output reg [7:0] port_b_pad_oe_n,
  input wire serial_transmit_out,
  output reg serial_receive_in,
  output reg external_interrupt_one,
  output reg capture_one_quad_a,
  output reg capture_two_quad_b,
  output reg capture_three_in,
  input wire pwm_one_out,
  input wire pwm_two_out,
  input wire pwm_three_out,
  input wire pwm_four_out,
  input wire pwm_five_out,
  input wire pwm_six_out,
  input wire timer_one_compare_out,
  input wire timer_two_compare_out,
  output reg timer_direction_in,
  output reg timer_clock_in
);

  reg [15:0] port_ab_function_select;
  reg [15:0] port_a_data_direction;
  reg [15:0] port_b_data_direction;
  reg [7:0] pad_a_meta;
  reg [7:0] pad_a_sync;
  reg [7:0] pad_b_meta;
  reg [7:0] pad_b_sync;
  wire [7:0] sel_a = port_ab_function_select[`SPM_PORT_B_LSB-1:0]; // see RQ5
  wire [7:0] sel_b = port_ab_function_select[15:`SPM_PORT_B_LSB]; // see RQ5
  wire wr_en = psel & penable & pwrite;
  wire rd_en = psel & ~pwrite;
  wire hit = (paddr == `SPM_OFS_SELECT) || (paddr == `SPM_OFS_PORT_A) ||
    (paddr == `SPM_OFS_PORT_B);
  wire [7:0] a_dir = port_a_data_direction[15:`SPM_DIR_LSB];
  wire [7:0] b_dir = port_b_data_direction[15:`SPM_DIR_LSB];
  wire [7:0] a_rd_data;
  wire [7:0] b_rd_data;
  wire [7:0] periph_a_out;
  wire [7:0] periph_a_drv;
  wire [7:0] periph_b_out;
  wire [7:0] periph_b_drv;
  wire sel_hit;
  wire a_hit;
  wire b_hit;
  wire wr_sel;
  wire wr_a;
  wire wr_b;

  wire [7:0] next_a_out;
  wire [7:0] next_a_oe_n;
  wire [7:0] next_b_out;
  wire [7:0] next_b_oe_n;
  reg [31:0] next_prdata;
  reg next_serial_receive_in;
  reg next_external_interrupt_one;
  reg next_capture_one_quad_a;
  reg next_capture_two_quad_b;
  reg next_capture_three_in;
  reg next_timer_direction_in;
  reg next_timer_clock_in;

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;

  // Address decode and write strobes
  assign sel_hit = (paddr == `SPM_OFS_SELECT);
  assign a_hit = (paddr == `SPM_OFS_PORT_A);
  assign b_hit = (paddr == `SPM_OFS_PORT_B);
  assign wr_sel = wr_en & sel_hit;
  assign wr_a = wr_en & a_hit;
  assign wr_b = wr_en & b_hit;

  // Port A pins 0-7: serial transmit, serial receive, interrupt one,
  // capture one, capture two, capture three, pwm one, pwm two.
  // Port B pins 0-7: pwm three to six, timer one and two compare,
  // timer direction, timer clock.
  // Input functions leave their pads undriven in peripheral mode.
  // Peripheral outputs, and whether the peripheral drives that pad
  assign periph_a_out = {pwm_two_out, pwm_one_out, 5'h00, serial_transmit_out}; // see RQ8
  assign periph_a_drv = 8'hC1; // see RQ8
  assign periph_b_out = {2'h0, timer_two_compare_out, timer_one_compare_out,
    pwm_six_out, pwm_five_out, pwm_four_out, pwm_three_out}; // see RQ8
  assign periph_b_drv = 8'h3F; // see RQ8

  // Port A pad inputs synchronised before any use
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_a_meta <= 8'h00;
      pad_a_sync <= 8'h00;
    end else begin
      pad_a_meta <= port_a_pad_in;
      pad_a_sync <= pad_a_meta;
    end
  end

  // Port B pad inputs, same two-stage synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_b_meta <= 8'h00;
      pad_b_sync <= 8'h00;
    end else begin
      pad_b_meta <= port_b_pad_in;
      pad_b_sync <= pad_b_meta;
    end
  end

  // Function select; all pins come up as general-purpose I/O
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_ab_function_select <= `SPM_SELECT_RESET; // see RQ6
    end else if (wr_sel) begin
      port_ab_function_select <= pwdata[15:0]; // see RQ4
    end
  end

  // Port A data and direction; data kept even while pins are inputs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_data_direction <= `SPM_DATDIR_RESET;
    end else if (wr_a) begin
      port_a_data_direction <= pwdata[15:0]; // see RQ7
    end
  end

  // Port B data and direction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_data_direction <= `SPM_DATDIR_RESET;
    end else if (wr_b) begin
      port_b_data_direction <= pwdata[15:0]; // see RQ7
    end
  end

  // Per-pin next pad state and readback
  genvar n;
  generate
    for (n = 0; n < 8; n = n + 1) begin : g_pin
      // Input pins in I/O mode read the pad, all others the stored bit
      // see RQ3
      assign a_rd_data[n] = (!sel_a[n] && !a_dir[n]) ? pad_a_sync[n] :
        port_a_data_direction[n];
      assign b_rd_data[n] = (!sel_b[n] && !b_dir[n]) ? pad_b_sync[n] :
        port_b_data_direction[n];
      // Peripheral mode ignores the stored direction and data
      assign next_a_out[n] = sel_a[n] ? periph_a_out[n] : // see RQ1, RQ10
        port_a_data_direction[n]; // see RQ3
      assign next_a_oe_n[n] = sel_a[n] ? ~periph_a_drv[n] : ~a_dir[n]; // see RQ2, RQ9
      assign next_b_out[n] = sel_b[n] ? periph_b_out[n] : // see RQ1, RQ10
        port_b_data_direction[n]; // see RQ3
      assign next_b_oe_n[n] = sel_b[n] ? ~periph_b_drv[n] : ~b_dir[n]; // see RQ2, RQ9
    end
  endgenerate

  // Pad drive registered so a decode change never glitches a pad
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_pad_out <= 8'h00;
    end else begin
      port_a_pad_out <= next_a_out;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_a_pad_oe_n <= 8'hFF;
    end else begin
      port_a_pad_oe_n <= next_a_oe_n;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_pad_out <= 8'h00;
    end else begin
      port_b_pad_out <= next_b_out;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_b_pad_oe_n <= 8'hFF;
    end else begin
      port_b_pad_oe_n <= next_b_oe_n;
    end
  end

  // Peripheral inputs see the pad only when their function is selected
  // Unselected receiver rests high so it never sees a false start bit
  always @* begin
    if (sel_a[1]) begin
      next_serial_receive_in = pad_a_sync[1]; // see RQ8
    end else begin
      next_serial_receive_in = 1'b1;
    end
  end

  always @* begin
    if (sel_a[2]) begin
      next_external_interrupt_one = pad_a_sync[2]; // see RQ8
    end else begin
      next_external_interrupt_one = 1'b0;
    end
  end

  always @* begin
    if (sel_a[3]) begin
      next_capture_one_quad_a = pad_a_sync[3]; // see RQ8
    end else begin
      next_capture_one_quad_a = 1'b0;
    end
  end

  always @* begin
    if (sel_a[4]) begin
      next_capture_two_quad_b = pad_a_sync[4]; // see RQ8
    end else begin
      next_capture_two_quad_b = 1'b0;
    end
  end

  always @* begin
    if (sel_a[5]) begin
      next_capture_three_in = pad_a_sync[5]; // see RQ8
    end else begin
      next_capture_three_in = 1'b0;
    end
  end

  always @* begin
    if (sel_b[6]) begin
      next_timer_direction_in = pad_b_sync[6]; // see RQ8
    end else begin
      next_timer_direction_in = 1'b0;
    end
  end

  always @* begin
    if (sel_b[7]) begin
      next_timer_clock_in = pad_b_sync[7]; // see RQ8
    end else begin
      next_timer_clock_in = 1'b0;
    end
  end

  // Peripheral inputs registered, one process each
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_receive_in <= 1'b1;
    end else begin
      serial_receive_in <= next_serial_receive_in;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      external_interrupt_one <= 1'b0;
    end else begin
      external_interrupt_one <= next_external_interrupt_one;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_one_quad_a <= 1'b0;
    end else begin
      capture_one_quad_a <= next_capture_one_quad_a;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_two_quad_b <= 1'b0;
    end else begin
      capture_two_quad_b <= next_capture_two_quad_b;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_three_in <= 1'b0;
    end else begin
      capture_three_in <= next_capture_three_in;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_direction_in <= 1'b0;
    end else begin
      timer_direction_in <= next_timer_direction_in;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_clock_in <= 1'b0;
    end else begin
      timer_clock_in <= next_timer_clock_in;
    end
  end

  // Read mux; upper half and unmapped offsets read zero
  always @* begin
    if (paddr == `SPM_OFS_SELECT) begin
      next_prdata = {16'h0000, port_ab_function_select};
    end else if (paddr == `SPM_OFS_PORT_A) begin
      next_prdata = {16'h0000, a_dir, a_rd_data};
    end else if (paddr == `SPM_OFS_PORT_B) begin
      next_prdata = {16'h0000, b_dir, b_rd_data};
    end else begin
      next_prdata = 32'h00000000;
    end
  end

  // Read data, registered in the setup phase and held until the next read
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en && !penable) begin
      prdata <= next_prdata;
    end
  end

endmodule
`default_nettype wire

/* shared/spm_consts.vh */
// Constants for the port A/B pin mux and general-purpose I/O block.
// Assumes a 32-bit APB slave on pclk; registers are 16 bits in the low half.
// Summary of operation
// RQ1: Select bit 1 picks peripheral, 0 picks I/O
// RQ2: Direction bit 0 input, 1 output
// RQ3: Input reads pad; output drives data bit
// RQ4: Sixteen-bit select and data/direction registers
// RQ5: Select bits 0-7 port A, 8-15 port B
// RQ6: All select bits reset to zero
// RQ7: Bit n data, bit n+8 direction
// RQ8: Fixed peripheral function per pin as listed
// RQ9: Every pin bidirectional, individually configurable
// RQ10: Peripheral mode ignores stored direction and data
`ifndef SPM_CONSTS_VH
`define SPM_CONSTS_VH
`define SPM_OFS_SELECT 12'h000
`define SPM_OFS_PORT_A 12'h004
`define SPM_OFS_PORT_B 12'h008
`define SPM_SELECT_RESET 16'h0000
`define SPM_DATDIR_RESET 16'h0000
`define SPM_DIR_LSB 8
`define SPM_PORT_B_LSB 8
`endif

/* sim/spm_pad_model.sv */
// Pad model for ports A and B: resolves each wire from the block's drive.
// Assumes oe_n low means the block drives; otherwise the board level ext wins.
`timescale 1ns/1ns
`default_nettype none
module spm_pad_model #(
  parameter int W = 16
) (
  input wire logic [W-1:0] oe_n,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] ext,
  output logic [W-1:0] pad
);
  assign pad = (~oe_n & out) | (oe_n & ext);
endmodule
`default_nettype wire

/* sim/spm_pin_mux_monitor.sv */
// Checker for the port A/B pin mux, watching top-level ports only.
// Assumes it is bound into spm_pin_mux.
`timescale 1ns/1ns
`default_nettype none
module spm_pin_mux_monitor (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire pready,
  input wire pslverr,
  input wire [7:0] port_a_pad_oe_n,
  input wire [7:0] port_b_pad_oe_n,
  input wire serial_receive_in,
  input wire external_interrupt_one,
  input wire timer_direction_in
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_high: assert property (psel |-> pready) else $error("pready low");
  chk_err_bad: assert property (psel && penable && paddr > 12'h008 |-> pslverr)
    else $error("unmapped not flagged");
  chk_err_ok: assert property (psel && penable && paddr == 12'h004 |-> !pslverr)
    else $error("mapped flagged");
  chk_rx_idle: assert property (!port_a_pad_oe_n[1] |-> serial_receive_in)
    else $error("rx not idle");
  chk_int_idle: assert property (!port_a_pad_oe_n[2] |-> !external_interrupt_one)
    else $error("int not idle");
  chk_tdir_idle: assert property (!port_b_pad_oe_n[6] |-> !timer_direction_in)
    else $error("tdir not idle");
  chk_reset_in: assert property ($rose(presetn) |-> &{port_a_pad_oe_n, port_b_pad_oe_n})
    else $error("pad driven after reset");
  chk_oe_cause: assert property ($changed({port_a_pad_oe_n, port_b_pad_oe_n})
    |-> $past(psel && penable && pwrite, 2)) else $error("enable moved alone");
endmodule
bind spm_pin_mux spm_pin_mux_monitor spm_pin_mux_monitor_i (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pready, .pslverr, .port_a_pad_oe_n, .port_b_pad_oe_n,
  .serial_receive_in, .external_interrupt_one, .timer_direction_in);
`default_nettype wire

/* sim/tb_spm_pin_mux.sv */
// Self-checking bench for the port A/B pin mux over APB.
// Assumes the pad model resolves both ports from one 16-bit board level.
`timescale 1ns/1ns
`default_nettype none
module tb_spm_pin_mux;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] a_in, a_out, a_oe, b_in, b_out, b_oe;
  logic [8:0] po;
  logic [6:0] pi;
  logic [15:0] ext;
  int errors, compares;
  logic [11:0] ra[4] = '{12'h000, 12'h004, 12'h008, 12'h00C};
  logic [31:0] rw[4] = '{32'hFFFF0000, 32'h00000F5A, 32'h0000F0FF, 32'h00000001};
  logic [31:0] rr[4] = '{32'h0, 32'h00000F3A, 32'h0000F0F5, 32'h0};
  spm_pin_mux spm_pin_mux_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .port_a_pad_in(a_in), .port_a_pad_out(a_out),
    .port_a_pad_oe_n(a_oe), .port_b_pad_in(b_in), .port_b_pad_out(b_out),
    .port_b_pad_oe_n(b_oe), .serial_transmit_out(po[0]), .pwm_one_out(po[1]),
    .pwm_two_out(po[2]), .pwm_three_out(po[3]), .pwm_four_out(po[4]), .pwm_five_out(po[5]),
    .pwm_six_out(po[6]), .timer_one_compare_out(po[7]), .timer_two_compare_out(po[8]),
    .serial_receive_in(pi[0]), .external_interrupt_one(pi[1]), .capture_one_quad_a(pi[2]),
    .capture_two_quad_b(pi[3]), .capture_three_in(pi[4]), .timer_direction_in(pi[5]),
    .timer_clock_in(pi[6]));
  spm_pad_model #(.W(16)) spm_pad_model_i (.oe_n({b_oe, a_oe}), .out({b_out, a_out}),
    .ext(ext), .pad({b_in, a_in}));
  task tally_and_finish;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 50);
    if (n >= 50) begin
      errors++;
      tally_and_finish;
    end
    r = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  initial begin
    pclk = 1'h0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    presetn = 1'h0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    po = 9'h0;
    ext = 16'hA53C;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    foreach (ra[i]) begin
      xfer(1'h1, ra[i], rw[i], rd);
      xfer(1'h0, ra[i], 32'h0, rd);
      chk(rd, rr[i]);
    end
    chk({a_oe, b_oe, a_in}, {16'hF00F, 8'h3A});
    po <= 9'h155;
    xfer(1'h1, 12'h000, 32'h0000FFFF, rd);
    repeat (5) @(posedge pclk);
    @(negedge pclk);
    chk({a_oe, b_oe, pi}, {16'h3EC0, 7'h5E});
    chk({a_out[7:6], a_out[0], b_out[5:0]}, {2'h2, 1'h1, 6'h2A});
    xfer(1'h0, 12'h004, 32'h0, rd);
    chk(rd, 32'h00000F5A);
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    xfer(1'h0, 12'h000, 32'h0, rd);
    chk({rd[15:0], a_oe, b_oe}, 32'h0000FFFF);
    tally_and_finish;
  end
endmodule
`default_nettype wire
